/* File: inc/sph_pkg.sv */
// Shared constants for the slave peripheral host port
package sph_pkg;
   localparam int DATA_W = 8;
   localparam int NIB_W = 4;
   // Status register bit positions
   localparam int ST_OBF = 0;
   localparam int ST_IBF = 1;
   localparam int ST_F0 = 2;
   localparam int ST_F1 = 3;
   localparam int ST_USR_LO = 4;
   localparam int ST_USR_HI = 7;
   // Port two line positions
   localparam int P2_OBF = 4;
   localparam int P2_IBF = 5;
   localparam int P2_DRQ = 6;
   localparam int P2_DMA_ACKNOWLEDGE_N = 7;
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] PORT_RST = 8'hff;
   localparam logic [3:0] NIB_RST = 4'h0;
   // Expander strobe length in ns and cycles at 40 MHz
   localparam int CLK_NS = 25;
   localparam int STROBE_NS = 700;
   localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   // Internal core command codes
   typedef enum logic [3:0] {
      SPH_CMD_NONE = 4'h0,
      SPH_CMD_OUT = 4'h1,
      SPH_CMD_IN = 4'h2,
      SPH_CMD_STS = 4'h3,
      SPH_CMD_FLAGS = 4'h4,
      SPH_CMD_DMA = 4'h5,
      SPH_CMD_CNT = 4'h6,
      SPH_CMD_F0 = 4'h7
   } sph_cmd_t;
   // Expander strobe states
   typedef enum logic [1:0] {
      SPH_EX_IDLE = 2'b01,
      SPH_EX_PULSE = 2'b10
   } sph_ex_t;
endpackage : sph_pkg

/* File: rtl/sph_host_port.sv */
// Master-side host port of the slave peripheral controller
//
// Function
// R1: Master read strobe low fetches output buffer or status word.
// R2: Master write strobe low captures byte into input buffer.
// R3: Data lines driven only during selected master read.
// R4: One data register each direction plus readable status byte (here master-to-core data goes through a two-entry buffer).
// R5: Buffer state by polling, interrupt flags, or DMA handshake.
// R6: External fetch select high forces external instruction fetch.
// R7: Single step low halts after each instruction, marked by strobe.
// R8: Test input zero is sampled for its branch conditions.
// R9: Test input one is sampled for its branch conditions.
// R10: After start counting, test input one clocks the counter.
// R11: Ports one and two are quasi-bidirectional eight-line ports.
// R12: External fetch puts upper four address bits on port two low.
// R13: Port two low nibble also carries expander bus traffic.
// R14: Port two upper lines are port lines or flag/DMA lines.
// R15: Expander transfer emits a strobe pulse on the program pin.
// R16: Status holds user bits, two flags, input full, output full.
// R17: Load status copies accumulator high nibble, low nibble kept.
// R18: Flags update on trailing rising edge of read or write.
// R19: Enable flags maps output full to line four, input full five (here line five carries input full inverted).
// R20: Reset clears flags and releases the data bus.
// R21: Strobes act only with chip select low; select picks path (here DMA acknowledge low also selects once DMA is enabled).
// R22: Master write sets input full; core read clears; reverse too (here input full clears only when the core reads the last buffered byte).
`timescale 1ns/10ps
module sph_host_port #(
   parameter int DATA_W = sph_pkg::DATA_W,
   parameter int STROBE_CYC = sph_pkg::STROBE_CYC
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Master bus pins
   input wire logic i_cs_n,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire logic i_register_select,
   input wire logic [DATA_W-1:0] i_db,
   output logic [DATA_W-1:0] o_db,
   output logic o_db_oe,
   // Control pins
   input wire logic i_external_fetch_select,
   input wire logic i_single_step_n,
   input wire logic i_test_input_zero,
   input wire logic i_test_input_one,
   output logic o_sync,
   output logic o_expander_strobe,
   // Port pins
   input wire logic [7:0] i_p1,
   output logic [7:0] o_p1,
   output logic [7:0] o_p1_oe,
   input wire logic [7:0] i_p2,
   output logic [7:0] o_p2,
   output logic [7:0] o_p2_oe,
   // Core command side
   input wire logic i_cmd_valid,
   output logic o_cmd_ready,
   input wire sph_pkg::sph_cmd_t i_cmd,
   input wire logic [DATA_W-1:0] i_cmd_data,
   input wire logic i_insn_done,
   input wire logic [3:0] i_fetch_addr_hi,
   input wire logic i_fetch_ext,
   input wire logic i_exp_start,
   input wire logic [3:0] i_exp_nibble,
   input wire logic [7:0] i_p1_latch,
   input wire logic [7:0] i_p2_latch,
   // Core data from master, two-entry buffer
   output logic o_in_valid,
   input wire logic i_in_ready,
   output logic [DATA_W-1:0] o_in_data,
   output logic o_in_is_cmd,
   // Core status view
   output logic o_use_external_fetch,
   output logic o_halt,
   output logic o_test_zero,
   output logic o_test_one,
   output logic o_count_tick,
   output logic o_count_from_pin,
   output logic [7:0] o_p1_in,
   output logic [7:0] o_p2_in,
   output logic [3:0] o_exp_in,
   output logic [DATA_W-1:0] o_status
);
   // ---------------------------------------------------------------
   // Synchronisers
   // ---------------------------------------------------------------
   localparam int SW = 9 + DATA_W + 16;
   logic [SW-1:0] s1_ff;
   logic [SW-1:0] s2_ff;
   wire [SW-1:0] raw = {i_cs_n, i_rd_n, i_wr_n, i_register_select, i_external_fetch_select,
      i_single_step_n, i_test_input_zero, i_test_input_one, i_p2[sph_pkg::P2_DMA_ACKNOWLEDGE_N], i_db,
      i_p1, i_p2};
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         s1_ff <= '1;
         s2_ff <= '1;
      end else begin
         s1_ff <= raw;
         s2_ff <= s1_ff;
      end
   end
   wire cs_n = s2_ff[SW-1];
   wire rd_n = s2_ff[SW-2];
   wire wr_n = s2_ff[SW-3];
   wire rsel = s2_ff[SW-4];
   wire ext_sel = s2_ff[SW-5];
   wire step_n = s2_ff[SW-6];
   wire t0 = s2_ff[SW-7];
   wire t1 = s2_ff[SW-8];
   wire dma_acknowledge_n_n = s2_ff[SW-9];
   wire [DATA_W-1:0] db_s = s2_ff[16 +: DATA_W];
   wire [7:0] p1_s = s2_ff[8 +: 8];
   wire [7:0] p2_s = s2_ff[0 +: 8];

   // ---------------------------------------------------------------
   // Strobe edge detection
   // ---------------------------------------------------------------
   logic rd_d_ff;
   logic wr_d_ff;
   logic t1_d_ff;
   logic [DATA_W-1:0] wr_data_ff;
   logic wr_rsel_ff;
   logic rd_rsel_ff;
   logic rd_sel_ff;
   logic wr_sel_ff;
   wire dma_on;
   wire sel = !cs_n || (dma_on && !dma_acknowledge_n_n); // [R21]
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         rd_d_ff <= 1'b1;
         wr_d_ff <= 1'b1;
         t1_d_ff <= 1'b1;
         wr_data_ff <= sph_pkg::RST_BYTE;
         wr_rsel_ff <= 1'b0;
         rd_rsel_ff <= 1'b0;
         rd_sel_ff <= 1'b0;
         wr_sel_ff <= 1'b0;
      end else begin
         rd_d_ff <= rd_n;
         wr_d_ff <= wr_n;
         t1_d_ff <= t1;
         if (!wr_n) begin
            wr_data_ff <= db_s; // [R2]
            wr_rsel_ff <= rsel && cs_n == 1'b0;
            wr_sel_ff <= sel;
         end
         if (!rd_n) begin
            rd_rsel_ff <= rsel;
            rd_sel_ff <= sel;
         end
      end
   end
   wire rd_rise = rd_n && !rd_d_ff && rd_sel_ff; // [R18]
   wire wr_rise = wr_n && !wr_d_ff && wr_sel_ff; // [R18]
   wire host_rd_done = rd_rise && !rd_rsel_ff;
   wire host_wr_done = wr_rise;

   // ---------------------------------------------------------------
   // Two-entry buffer toward the core
   // ---------------------------------------------------------------
   logic [DATA_W:0] buf_ff [2];
   logic [1:0] cnt_ff;
   logic rp_ff;
   logic wp_ff;
   wire buf_push = host_wr_done && cnt_ff != 2'd2;
   wire buf_pop = o_in_valid && i_in_ready;
   assign o_in_valid = cnt_ff != 2'd0;
   assign o_in_data = buf_ff[rp_ff][DATA_W-1:0];
   assign o_in_is_cmd = buf_ff[rp_ff][DATA_W];
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         cnt_ff <= 2'd0;
         rp_ff <= 1'b0;
         wp_ff <= 1'b0;
         buf_ff[0] <= '0;
         buf_ff[1] <= '0;
      end else begin
         if (buf_push) begin
            buf_ff[wp_ff] <= {wr_rsel_ff, wr_data_ff};
            wp_ff <= !wp_ff;
         end
         if (buf_pop) begin
            rp_ff <= !rp_ff;
         end
         cnt_ff <= cnt_ff + {1'b0, buf_push} - {1'b0, buf_pop};
      end
   end

   // ---------------------------------------------------------------
   // Status and output buffer
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] out_ff;
   logic [3:0] usr_ff;
   logic f0_ff;
   logic f1_ff;
   logic ibf_ff;
   logic obf_ff;
   logic flags_en_ff;
   logic dma_en_ff;
   logic drq_ff;
   logic count_pin_ff;
   wire cmd_take = i_cmd_valid && o_cmd_ready;
   wire core_out = cmd_take && i_cmd == sph_pkg::SPH_CMD_OUT;
   wire core_sts = cmd_take && i_cmd == sph_pkg::SPH_CMD_STS;
   wire core_f0 = cmd_take && i_cmd == sph_pkg::SPH_CMD_F0;
   assign o_cmd_ready = 1'b1;
   assign dma_on = dma_en_ff;
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         out_ff <= sph_pkg::RST_BYTE;
         usr_ff <= sph_pkg::NIB_RST;
         f0_ff <= 1'b0;
         f1_ff <= 1'b0;
         ibf_ff <= 1'b0; // [R20]
         obf_ff <= 1'b0; // [R20]
         flags_en_ff <= 1'b0;
         dma_en_ff <= 1'b0;
         drq_ff <= 1'b0;
         count_pin_ff <= 1'b0;
      end else begin
         if (core_out) begin
            out_ff <= i_cmd_data;
         end
         if (core_sts) begin
            usr_ff <= i_cmd_data[sph_pkg::ST_USR_HI:sph_pkg::ST_USR_LO]; // [R17]
         end
         if (host_wr_done) begin
            f1_ff <= wr_rsel_ff; // [R21]
            ibf_ff <= 1'b1; // [R22]
         end else if (buf_pop) begin
            ibf_ff <= cnt_ff != 2'd1; // [R22]
         end
         if (core_out) begin
            obf_ff <= 1'b1; // [R22]
         end else if (host_rd_done) begin
            obf_ff <= 1'b0; // [R22]
         end
         if (core_f0) begin
            f0_ff <= i_cmd_data[0];
         end
         if (cmd_take && i_cmd == sph_pkg::SPH_CMD_FLAGS) begin
            flags_en_ff <= 1'b1; // [R19]
         end
         if (cmd_take && i_cmd == sph_pkg::SPH_CMD_DMA) begin
            dma_en_ff <= 1'b1; // [R14]
         end
         if (cmd_take && i_cmd == sph_pkg::SPH_CMD_CNT) begin
            count_pin_ff <= i_cmd_data[0]; // [R10]
         end
         if (core_out && dma_en_ff) begin
            drq_ff <= 1'b1; // [R5]
         end else if ((rd_rise || wr_rise) && !dma_acknowledge_n_n) begin
            drq_ff <= 1'b0;
         end
      end
   end
   assign o_status = {usr_ff, f1_ff, f0_ff, ibf_ff, obf_ff}; // [R16] [R4]

   // ---------------------------------------------------------------
   // Data bus drive
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] db_ff;
   logic db_oe_ff;
   wire rd_active = sel && !rd_n; // [R3]
   wire [DATA_W-1:0] rd_mux = rsel ? o_status : out_ff; // [R1] [R5]
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         db_ff <= sph_pkg::RST_BYTE;
         db_oe_ff <= 1'b0; // [R20]
      end else begin
         db_ff <= rd_mux;
         db_oe_ff <= rd_active;
      end
   end
   assign o_db = db_ff;
   assign o_db_oe = db_oe_ff;

   // ---------------------------------------------------------------
   // Expander strobe
   // ---------------------------------------------------------------
   sph_pkg::sph_ex_t ex_ff;
   sph_pkg::sph_ex_t nxt_ex;
   logic [7:0] ex_cnt_ff;
   logic [3:0] ex_nib_ff;
   wire ex_last = ex_cnt_ff == 8'(STROBE_CYC - 1);
   always_comb begin
      nxt_ex = ex_ff;
      unique case (ex_ff)
         sph_pkg::SPH_EX_IDLE: begin
            if (i_exp_start) begin
               nxt_ex = sph_pkg::SPH_EX_PULSE;
            end
         end
         sph_pkg::SPH_EX_PULSE: begin
            if (ex_last) begin
               nxt_ex = sph_pkg::SPH_EX_IDLE;
            end
         end
         default: nxt_ex = sph_pkg::SPH_EX_IDLE;
      endcase
   end
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         ex_ff <= sph_pkg::SPH_EX_IDLE;
         ex_cnt_ff <= 8'h00;
         ex_nib_ff <= sph_pkg::NIB_RST;
      end else begin
         ex_ff <= nxt_ex;
         ex_cnt_ff <= (ex_ff == sph_pkg::SPH_EX_PULSE) ? ex_cnt_ff + 8'h01 : 8'h00;
         if (i_exp_start && ex_ff == sph_pkg::SPH_EX_IDLE) begin
            ex_nib_ff <= i_exp_nibble;
         end
      end
   end
   assign o_expander_strobe = ex_ff != sph_pkg::SPH_EX_PULSE; // [R15]

   // ---------------------------------------------------------------
   // Ports, test inputs, stepping
   // ---------------------------------------------------------------
   logic [7:0] p2_ff;
   logic [7:0] p1_ff;
   logic sync_ff;
   wire ex_busy = ex_ff == sph_pkg::SPH_EX_PULSE;
   wire [3:0] p2_lo = i_fetch_ext ? i_fetch_addr_hi : // [R12]
      (ex_busy ? ex_nib_ff : i_p2_latch[3:0]); // [R13]
   wire obf_pin = flags_en_ff ? (i_p2_latch[sph_pkg::P2_OBF] & obf_ff) // [R19]
      : i_p2_latch[sph_pkg::P2_OBF];
   wire ibf_pin = flags_en_ff ? (i_p2_latch[sph_pkg::P2_IBF] & !ibf_ff)
      : i_p2_latch[sph_pkg::P2_IBF];
   wire drq_pin = dma_en_ff ? drq_ff : i_p2_latch[sph_pkg::P2_DRQ]; // [R14]
   wire dma_acknowledge_n_pin = dma_en_ff ? 1'b1 : i_p2_latch[sph_pkg::P2_DMA_ACKNOWLEDGE_N];
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         p1_ff <= sph_pkg::PORT_RST;
         p2_ff <= sph_pkg::PORT_RST;
         sync_ff <= 1'b0;
      end else begin
         p1_ff <= i_p1_latch; // [R11]
         p2_ff <= {dma_acknowledge_n_pin, drq_pin, ibf_pin, obf_pin, p2_lo};
         sync_ff <= i_insn_done; // [R7]
      end
   end
   // Quasi-bidirectional: drive only a low, pull-up elsewhere; port two low nibble fully driven during fetch or expander
   assign o_p1 = p1_ff;
   assign o_p1_oe = ~p1_ff; // [R11]
   assign o_p2 = p2_ff;
   assign o_p2_oe = {~p2_ff[7:4], (i_fetch_ext || ex_busy) ? 4'hf : ~p2_ff[3:0]};
   assign o_sync = sync_ff;
   assign o_use_external_fetch = ext_sel; // [R6]
   assign o_halt = !step_n && i_insn_done; // [R7]
   assign o_test_zero = t0; // [R8]
   assign o_test_one = t1; // [R9]
   assign o_count_from_pin = count_pin_ff;
   assign o_count_tick = count_pin_ff && !t1 && t1_d_ff; // [R10]
   assign o_p1_in = p1_s;
   assign o_p2_in = p2_s;
   assign o_exp_in = p2_s[3:0];
endmodule : sph_host_port

/* File: bench/sph_host_port_props.sv */
// Assertion checker for the slave peripheral host port
`timescale 1ns/10ps
module sph_host_port_props #(
   parameter int STROBE_CYC = 2
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Watched pins
   input wire logic i_cs_n,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire logic i_register_select,
   input wire logic o_db_oe,
   input wire logic o_expander_strobe,
   input wire logic i_cmd_valid,
   input wire sph_pkg::sph_cmd_t i_cmd,
   input wire logic [7:0] i_cmd_data,
   input wire logic i_insn_done,
   input wire logic i_single_step_n,
   input wire logic o_halt,
   input wire logic o_sync,
   input wire logic i_fetch_ext,
   input wire logic [3:0] i_fetch_addr_hi,
   input wire logic [7:0] o_p2,
   input wire logic [7:0] o_p2_oe,
   input wire logic [7:0] o_status
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   logic [7:0] low_cnt_ff;
   always_ff @(posedge i_clk) begin
      if (!i_rstn || o_expander_strobe) begin
         low_cnt_ff <= 8'h00;
      end else begin
         low_cnt_ff <= low_cnt_ff + 8'h01;
      end
   end
   sequence wr_end;
      $rose(i_wr_n) ##0 $past(!i_cs_n);
   endsequence
   sequence rd_data_end;
      $rose(i_rd_n) ##0 $past(!i_cs_n && !i_register_select);
   endsequence
   sequence fetch_held;
      (i_fetch_ext && $stable(i_fetch_addr_hi)) [*3];
   endsequence
   reset_clear_a: assert property (disable iff (1'b0)
      !i_rstn |=> o_status == 8'h00 && !o_db_oe && o_expander_strobe)
      else $error("reset state wrong");
   oe_cause_a: assert property ($rose(o_db_oe) |-> $past(!i_rd_n, 2) && i_wr_n)
      else $error("bus driven without read");
   oe_release_a: assert property (i_rd_n [*4] |-> !o_db_oe)
      else $error("bus not released");
   ibf_set_a: assert property (wr_end |-> ##[2:5] o_status[sph_pkg::ST_IBF])
      else $error("input full not set");
   obf_clear_a: assert property (rd_data_end |-> ##[2:5] !o_status[sph_pkg::ST_OBF])
      else $error("output full not cleared");
   obf_set_a: assert property (i_cmd_valid && i_cmd == sph_pkg::SPH_CMD_OUT
      |=> o_status[sph_pkg::ST_OBF]) else $error("output full not set");
   sts_load_a: assert property (i_cmd_valid && i_cmd == sph_pkg::SPH_CMD_STS
      |=> o_status[7:4] == $past(i_cmd_data[7:4]) && o_status[3:0] == $past(o_status[3:0]))
      else $error("status load wrong");
   strobe_len_a: assert property ($rose(o_expander_strobe) |-> low_cnt_ff == STROBE_CYC)
      else $error("strobe length wrong");
   step_halt_a: assert property (i_insn_done && $past(!i_single_step_n, 2)
      |-> o_halt ##1 o_sync)
      else $error("step not marked");
   fetch_addr_a: assert property (fetch_held
      |-> o_p2_oe[3:0] == 4'hf && o_p2[3:0] == i_fetch_addr_hi)
      else $error("fetch address missing");
endmodule : sph_host_port_props
bind sph_host_port sph_host_port_props #(.STROBE_CYC(STROBE_CYC)) i_props (
   .i_clk(i_clk), .i_rstn(i_rstn), .i_cs_n(i_cs_n), .i_rd_n(i_rd_n), .i_wr_n(i_wr_n),
   .i_register_select(i_register_select), .o_db_oe(o_db_oe),
   .o_expander_strobe(o_expander_strobe), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
   .i_cmd_data(i_cmd_data), .i_insn_done(i_insn_done), .i_single_step_n(i_single_step_n),
   .o_halt(o_halt), .o_sync(o_sync), .i_fetch_ext(i_fetch_ext),
   .i_fetch_addr_hi(i_fetch_addr_hi), .o_p2(o_p2), .o_p2_oe(o_p2_oe), .o_status(o_status)
);

/* File: bench/sph_master_model.sv */
// Bus model of the master processor facing the host port
`timescale 1ns/10ps
module sph_master_model (
   // Clock
   input wire logic i_clk,
   // Bus pins toward the device
   output logic o_cs_n,
   output logic o_rd_n,
   output logic o_wr_n,
   output logic o_register_select,
   output logic [7:0] o_db,
   // Device read side
   input wire logic [7:0] i_db,
   input wire logic i_db_oe
);
   initial begin
      o_cs_n = 1'b1;
      o_rd_n = 1'b1;
      o_wr_n = 1'b1;
      o_register_select = 1'b0;
      o_db = 8'h00;
   end
   // Strobe low four cycles, data taken at the falling edge after, then high
   task automatic access(input logic wr, input logic sel, input logic rs,
      input logic [7:0] wdat, output logic [7:0] rdat, output logic oe);
      @(negedge i_clk);
      o_cs_n = !sel;
      o_register_select = rs;
      o_db = wdat;
      o_wr_n = !wr;
      o_rd_n = wr;
      repeat (4) @(posedge i_clk);
      @(negedge i_clk);
      rdat = i_db;
      oe = i_db_oe;
      o_wr_n = 1'b1;
      o_rd_n = 1'b1;
      o_db = ~wdat;
      @(negedge i_clk);
      o_cs_n = 1'b1;
      repeat (3) @(negedge i_clk);
   endtask : access
endmodule : sph_master_model

/* File: bench/sph_host_port_tb_top.sv */
// Self-checking testbench of the slave peripheral host port
`timescale 1ns/10ps
module sph_host_port_tb_top;
   localparam int STB = 4;
   logic clk, rstn, cs_n, rd_n, wr_n, rsel, db_oe, ext_sel, ss_n, t0, t1, sync, strobe;
   logic cmd_valid, cmd_ready, insn_done, fetch_ext, exp_start, in_valid, in_ready;
   logic in_is_cmd, use_ext, halt, tz, to, tick, cfp, oe;
   logic [7:0] mdb, db, p1, p1_oe, p2, p2_oe, cmd_data, in_data, p1_in, p2_in, status, rd;
   logic [3:0] fetch_hi, exp_in, nib;
   logic [7:0] p1_pin, p2_pin, p1_lat;
   sph_pkg::sph_cmd_t cmd;
   int bad_count, checks_done, cycles;
   sph_master_model m_master (.i_clk(clk), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
      .o_register_select(rsel), .o_db(mdb), .i_db(db), .i_db_oe(db_oe));
   sph_host_port #(.STROBE_CYC(STB)) i_sph_host_port (.i_clk(clk), .i_rstn(rstn),
      .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_register_select(rsel), .i_db(mdb),
      .o_db(db), .o_db_oe(db_oe), .i_external_fetch_select(ext_sel),
      .i_single_step_n(ss_n), .i_test_input_zero(t0), .i_test_input_one(t1),
      .o_sync(sync), .o_expander_strobe(strobe), .i_p1(p1_pin), .o_p1(p1), .o_p1_oe(p1_oe),
      .i_p2(p2_pin), .o_p2(p2), .o_p2_oe(p2_oe), .i_cmd_valid(cmd_valid),
      .o_cmd_ready(cmd_ready), .i_cmd(cmd), .i_cmd_data(cmd_data), .i_insn_done(insn_done),
      .i_fetch_addr_hi(fetch_hi), .i_fetch_ext(fetch_ext), .i_exp_start(exp_start),
      .i_exp_nibble(nib), .i_p1_latch(p1_lat), .i_p2_latch(8'hff), .o_in_valid(in_valid),
      .i_in_ready(in_ready), .o_in_data(in_data), .o_in_is_cmd(in_is_cmd),
      .o_use_external_fetch(use_ext), .o_halt(halt), .o_test_zero(tz), .o_test_one(to),
      .o_count_tick(tick), .o_count_from_pin(cfp), .o_p1_in(p1_in), .o_p2_in(p2_in),
      .o_exp_in(exp_in), .o_status(status));
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         summarize();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic core(input sph_pkg::sph_cmd_t c, input logic [7:0] d);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd = c;
      cmd_data = d;
      @(negedge clk);
      cmd_valid = 1'b0;
      @(negedge clk);
   endtask : core
   task automatic t_write;
      m_master.access(1'b1, 1'b0, 1'b0, 8'h11, rd, oe);
      chk(8'(in_valid), 8'h00);
      m_master.access(1'b1, 1'b1, 1'b0, 8'ha5, rd, oe);
      chk(8'(status[1]), 8'h01);
      m_master.access(1'b1, 1'b1, 1'b1, 8'h3c, rd, oe);
      chk(8'(status[3]), 8'h01);
      m_master.access(1'b1, 1'b1, 1'b0, 8'h77, rd, oe);
      chk(in_data, 8'ha5);
      chk(8'(in_is_cmd), 8'h00);
      in_ready = 1'b1;
      @(negedge clk);
      in_ready = 1'b0;
      chk(in_data, 8'h3c);
      chk(8'(in_is_cmd), 8'h01);
      in_ready = 1'b1;
      @(negedge clk);
      in_ready = 1'b0;
      repeat (2) @(negedge clk);
      chk(8'(in_valid), 8'h00);
      chk(8'(status[1]), 8'h00);
   endtask : t_write
   task automatic t_read;
      core(sph_pkg::SPH_CMD_OUT, 8'h5a);
      chk(8'(status[0]), 8'h01);
      m_master.access(1'b0, 1'b1, 1'b0, 8'h00, rd, oe);
      chk(rd, 8'h5a);
      chk(8'(oe), 8'h01);
      chk(8'(db_oe), 8'h00);
      chk(8'(status[0]), 8'h00);
      core(sph_pkg::SPH_CMD_STS, 8'hc3);
      m_master.access(1'b0, 1'b1, 1'b1, 8'h00, rd, oe);
      chk(8'(rd[7:4]), 8'h0c);
      chk(rd & 8'h03, 8'h00);
      m_master.access(1'b0, 1'b0, 1'b1, 8'h00, rd, oe);
      chk(8'(oe), 8'h00);
      core(sph_pkg::SPH_CMD_F0, 8'h01);
      chk(8'(status[2]), 8'h01);
   endtask : t_read
   task automatic t_ports;
      p1_pin = 8'h3c;
      p2_pin = 8'ha5;
      p1_lat = 8'h5a;
      repeat (4) @(negedge clk);
      chk(p1_in, 8'h3c);
      chk(p2_in, 8'ha5);
      chk(8'(exp_in), 8'h05);
      chk(p1, 8'h5a);
      chk(p1_oe, 8'ha5);
      p2_pin = 8'hff;
      p1_lat = 8'hff;
   endtask : t_ports
   task automatic t_flags;
      core(sph_pkg::SPH_CMD_FLAGS, 8'h00);
      chk(8'(p2[5:4]), 8'h02);
      core(sph_pkg::SPH_CMD_OUT, 8'h77);
      chk(8'(p2[5:4]), 8'h03);
      core(sph_pkg::SPH_CMD_DMA, 8'h00);
      core(sph_pkg::SPH_CMD_OUT, 8'h99);
      chk(8'(p2[6]), 8'h01);
      p2_pin = 8'h7f;
      m_master.access(1'b0, 1'b0, 1'b0, 8'h00, rd, oe);
      p2_pin = 8'hff;
      chk(rd, 8'h99);
      chk(8'(oe), 8'h01);
      chk(8'(p2[6]), 8'h00);
      chk(8'(status[0]), 8'h00);
   endtask : t_flags
   task automatic t_misc;
      int n;
      ext_sel = 1'b1;
      t0 = 1'b1;
      fetch_ext = 1'b1;
      fetch_hi = 4'h9;
      repeat (5) @(negedge clk);
      chk(8'(use_ext), 8'h01);
      chk(8'(tz), 8'h01);
      chk(8'(to), 8'h00);
      chk(8'(p2[3:0]), 8'h09);
      fetch_ext = 1'b0;
      t0 = 1'b0;
      t1 = 1'b1;
      repeat (4) @(negedge clk);
      chk(8'(tz), 8'h00);
      chk(8'(to), 8'h01);
      core(sph_pkg::SPH_CMD_CNT, 8'h01);
      chk(8'(cfp), 8'h01);
      t1 = 1'b0;
      repeat (2) @(negedge clk);
      chk(8'(tick), 8'h01);
      @(negedge clk);
      chk(8'(tick), 8'h00);
      ss_n = 1'b0;
      repeat (3) @(negedge clk);
      insn_done = 1'b1;
      #1;
      chk(8'(halt), 8'h01);
      @(negedge clk);
      insn_done = 1'b0;
      chk(8'(sync), 8'h01);
      nib = 4'h6;
      exp_start = 1'b1;
      @(negedge clk);
      exp_start = 1'b0;
      @(negedge clk);
      chk(8'(p2[3:0]), 8'h06);
      chk(8'(p2_oe[3:0]), 8'h0f);
      n = 1;
      while (strobe === 1'b0 && n < 100) begin
         n++;
         @(negedge clk);
      end
      chk(8'(n), 8'(STB));
   endtask : t_misc
   task automatic summarize;
      $display("checks=%0d mismatches=%0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : summarize
   initial begin
      {clk, rstn, ext_sel, t0, t1, cmd_valid, insn_done, fetch_ext, exp_start} = 9'h000;
      {ss_n, in_ready, cmd_data, fetch_hi} = 14'h2000;
      cmd = sph_pkg::SPH_CMD_NONE;
      p1_pin = 8'hff;
      p2_pin = 8'hff;
      p1_lat = 8'hff;
      nib = 4'h0;
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      repeat (3) @(negedge clk);
      chk(8'(db_oe), 8'h00);
      chk(status, sph_pkg::RST_BYTE);
      chk(p1, sph_pkg::PORT_RST);
      chk(p1_oe, 8'h00);
      chk(p2_oe, 8'h00);
      chk(8'(cmd_ready), 8'h01);
      t_write();
      t_read();
      t_ports();
      t_misc();
      t_flags();
      summarize();
   end
endmodule : sph_host_port_tb_top
